// ===== rtl/ocg_top.v
// Oscillator configuration registers and clock interrupt logic
//
// Function
// - Low-speed wait code 3,2,1 gives 65536, 16384, 4096 clocks; 0 reserved.
// - High-speed wait codes 0..7 give 4 up to 65536 clocks in steps of four.
// - Internal frequency codes 0..5 select six rates; 6,7 reserved; resets to 3.
// - Type code 0 internal, 1 CR, 2 crystal or ceramic; 3 reserved; reset 0.
// - High-speed gain 0 min to 3 max, applies only for crystal; reset 1.
// - Three-bit low-speed gate capacitance code, 0 minimum up to 7 maximum.
// - Two-bit boost gain code drives the low-speed oscillator during startup.
// - Separate two-bit normal gain code drives it after startup.
// - Flag 5 marks low-speed stop, flag 4 marks trim done, held while pending.
// - Flags 2,1,0 mark high-speed, low-speed, internal stabilization done.
// - Writing one clears a flag, zero leaves it; all flags zero after reset.
// - Internal stable flag reads zero after reset; no event for reset startup.
// - Enable bits 5,4 gate stop and trim; bits 2,1,0 gate stabilization.
// - An enable bit set to one enables its interrupt; enables read and write.
//
// The implementer's own choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ocg_defs.vh"
module ocg_top #(
    parameter ADDR_W = 8,
    parameter CNT_W = 17,
    parameter [CNT_W-1:0] LS_WAIT_3 = `OCG_WAIT_65536,
    parameter [CNT_W-1:0] LS_WAIT_2 = `OCG_WAIT_16384,
    parameter [CNT_W-1:0] HS_WAIT_7 = `OCG_WAIT_65536,
    parameter [CNT_W-1:0] HS_WAIT_6 = `OCG_WAIT_16384,
    parameter [CNT_W-1:0] IN_WAIT = `OCG_IN_WAIT_DEF
) (
    // Clock and reset
    input wire CLOCK,
    input wire RESETN,
    // AXI4-Lite write address
    input wire S_AXI_AWVALID,
    output wire S_AXI_AWREADY,
    input wire [ADDR_W-1:0] S_AXI_AWADDR,
    input wire [2:0] S_AXI_AWPROT,
    // AXI4-Lite write data
    input wire S_AXI_WVALID,
    output wire S_AXI_WREADY,
    input wire [31:0] S_AXI_WDATA,
    input wire [3:0] S_AXI_WSTRB,
    // AXI4-Lite write response
    output wire S_AXI_BVALID,
    input wire S_AXI_BREADY,
    output wire [1:0] S_AXI_BRESP,
    // AXI4-Lite read address
    input wire S_AXI_ARVALID,
    output wire S_AXI_ARREADY,
    input wire [ADDR_W-1:0] S_AXI_ARADDR,
    input wire [2:0] S_AXI_ARPROT,
    // AXI4-Lite read data
    output wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    output wire [31:0] S_AXI_RDATA,
    output wire [1:0] S_AXI_RRESP,
    // Oscillator run levels and clock ticks
    input wire LS_OSC_ON,
    input wire LS_OSC_TICK,
    input wire HS_OSC_ON,
    input wire HS_OSC_TICK,
    input wire IN_OSC_ON,
    input wire IN_OSC_TICK,
    // Events from the stop detector and the trimmer
    input wire LS_STOP_EVT,
    input wire TRIM_DONE_EVT,
    // Oscillator settings
    output wire [2:0] LOW_SPEED_GATE_CAP_CODE,
    output wire [1:0] LOW_SPEED_GAIN,
    output wire LOW_SPEED_BOOSTING,
    output wire [2:0] HIGH_SPEED_INTERNAL_FREQ,
    output wire [1:0] HIGH_SPEED_OSC_TYPE,
    output wire [1:0] HIGH_SPEED_INVERTER_GAIN,
    output wire HIGH_SPEED_GAIN_EN,
    output wire [2:0] STABLE,
    // Interrupt
    output wire IRQ
);

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [15:0] ls_ctrl_q;
reg [15:0] ls_ctrl_d;
reg [15:0] hs_ctrl_q;
reg [15:0] hs_ctrl_d;
reg [15:0] flags_q;
reg [15:0] flags_d;
reg [15:0] en_q;
reg [15:0] en_d;
reg irq_q;
reg [2:0] stable_q;

// ----------------------------------------------------------------
// Bus state
// ----------------------------------------------------------------
reg aw_hold_q;
reg [ADDR_W-1:0] awaddr_q;
reg w_hold_q;
reg [15:0] wdata_q;
reg [1:0] wstrb_q;
reg bvalid_q;
reg [1:0] bresp_q;
reg rvalid_q;
reg [15:0] rdata_q;
reg [1:0] rresp_q;

wire do_wr;
wire wr_hit;
wire [15:0] wr_val;
wire ls_done;
wire hs_done;
wire in_done;
wire ls_busy;
wire hs_busy;
wire in_busy;
wire [15:0] evt_set;
wire [15:0] flag_clr;
wire [CNT_W-1:0] ls_target;
wire [CNT_W-1:0] hs_target;

// ----------------------------------------------------------------
// Helpers
// ----------------------------------------------------------------
function sel_ok;
    input [ADDR_W-1:0] a;
    begin
        sel_ok = (a[ADDR_W-1:4] == {(ADDR_W-4){1'b0}});
    end
endfunction

function [15:0] rd_mux;
    input [3:0] a;
    input [15:0] ls;
    input [15:0] hs;
    input [15:0] fl;
    input [15:0] en;
    begin
        case ({a[3:2], 2'b00})
            `OCG_OFF_LS_CTRL: rd_mux = ls;
            `OCG_OFF_HS_CTRL: rd_mux = hs;
            `OCG_OFF_FLAGS: rd_mux = fl;
            `OCG_OFF_ENABLES: rd_mux = en;
            default: rd_mux = 16'h0000;
        endcase
    end
endfunction

// Reserved code 0 falls back to the longest wait, the safe side
function [CNT_W-1:0] ls_wait;
    input [1:0] code;
    begin
        case (code)
            2'h3: ls_wait = LS_WAIT_3;
            2'h2: ls_wait = LS_WAIT_2;
            2'h1: ls_wait = `OCG_WAIT_4096;
            default: ls_wait = LS_WAIT_3;
        endcase
    end
endfunction

function [CNT_W-1:0] hs_wait;
    input [2:0] code;
    begin
        case (code)
            3'h0: hs_wait = `OCG_WAIT_4;
            3'h1: hs_wait = `OCG_WAIT_16;
            3'h2: hs_wait = `OCG_WAIT_64;
            3'h3: hs_wait = `OCG_WAIT_256;
            3'h4: hs_wait = `OCG_WAIT_1024;
            3'h5: hs_wait = `OCG_WAIT_4096;
            3'h6: hs_wait = HS_WAIT_6;
            default: hs_wait = HS_WAIT_7;
        endcase
    end
endfunction

// ----------------------------------------------------------------
// Write channels
// ----------------------------------------------------------------
// Address and data are taken in either order and held until both are in
assign S_AXI_AWREADY = ~aw_hold_q & ~bvalid_q;
assign S_AXI_WREADY = ~w_hold_q & ~bvalid_q;
assign do_wr = aw_hold_q & w_hold_q & ~bvalid_q;
assign wr_hit = sel_ok(awaddr_q);
assign wr_val = {wstrb_q[1] ? wdata_q[15:8] : 8'h00, wstrb_q[0] ? wdata_q[7:0] : 8'h00};

always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        aw_hold_q <= 1'b0;
        awaddr_q <= {ADDR_W{1'b0}};
        w_hold_q <= 1'b0;
        wdata_q <= 16'h0000;
        wstrb_q <= 2'h0;
        bvalid_q <= 1'b0;
        bresp_q <= `OCG_RESP_OKAY;
    end
    else
    begin
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            aw_hold_q <= 1'b1;
            awaddr_q <= S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            w_hold_q <= 1'b1;
            wdata_q <= S_AXI_WDATA[15:0];
            wstrb_q <= S_AXI_WSTRB[1:0];
        end
        if (do_wr)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? `OCG_RESP_OKAY : `OCG_RESP_SLVERR;
        end
        else if (bvalid_q && S_AXI_BREADY)
        begin
            bvalid_q <= 1'b0;
        end
    end
end

assign S_AXI_BVALID = bvalid_q;
assign S_AXI_BRESP = bresp_q;

// ----------------------------------------------------------------
// Read channels
// ----------------------------------------------------------------
assign S_AXI_ARREADY = ~rvalid_q;

// Reads have no side effect; flags clear only by writing ones
always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        rvalid_q <= 1'b0;
        rdata_q <= 16'h0000;
        rresp_q <= `OCG_RESP_OKAY;
    end
    else if (S_AXI_ARVALID && !rvalid_q)
    begin
        rvalid_q <= 1'b1;
        if (sel_ok(S_AXI_ARADDR))
        begin
            rdata_q <= rd_mux(S_AXI_ARADDR[3:0], ls_ctrl_q, hs_ctrl_q, flags_q, en_q);
            rresp_q <= `OCG_RESP_OKAY;
        end
        else
        begin
            rdata_q <= 16'h0000;
            rresp_q <= `OCG_RESP_SLVERR;
        end
    end
    else if (rvalid_q && S_AXI_RREADY)
    begin
        rvalid_q <= 1'b0;
    end
end

assign S_AXI_RVALID = rvalid_q;
assign S_AXI_RDATA = {16'h0000, rdata_q};
assign S_AXI_RRESP = rresp_q;

// ----------------------------------------------------------------
// Control registers
// ----------------------------------------------------------------
// Byte strobes merge into the old value; reserved bits stay zero
always @*
begin
    ls_ctrl_d = ls_ctrl_q;
    hs_ctrl_d = hs_ctrl_q;
    en_d = en_q;
    if (do_wr && wr_hit)
    begin
        case ({awaddr_q[3:2], 2'b00})
            `OCG_OFF_LS_CTRL:
            begin
                ls_ctrl_d[15:8] = wstrb_q[1] ? wdata_q[15:8] : ls_ctrl_q[15:8];
                ls_ctrl_d[7:0] = wstrb_q[0] ? wdata_q[7:0] : ls_ctrl_q[7:0];
                ls_ctrl_d = ls_ctrl_d & `OCG_LS_MASK;
            end
            `OCG_OFF_HS_CTRL:
            begin
                hs_ctrl_d[15:8] = wstrb_q[1] ? wdata_q[15:8] : hs_ctrl_q[15:8];
                hs_ctrl_d[7:0] = wstrb_q[0] ? wdata_q[7:0] : hs_ctrl_q[7:0];
                hs_ctrl_d = hs_ctrl_d & `OCG_HS_MASK;
            end
            `OCG_OFF_ENABLES:
            begin
                en_d[15:8] = wstrb_q[1] ? wdata_q[15:8] : en_q[15:8];
                en_d[7:0] = wstrb_q[0] ? wdata_q[7:0] : en_q[7:0];
                en_d = en_d & `OCG_IRQ_MASK;
            end
            default:
            begin
                en_d = en_q;
            end
        endcase
    end
end

// ----------------------------------------------------------------
// Interrupt flags
// ----------------------------------------------------------------
assign evt_set = {10'h000, LS_STOP_EVT, TRIM_DONE_EVT, 1'b0, hs_done, ls_done, in_done};
assign flag_clr = (do_wr && wr_hit && ({awaddr_q[3:2], 2'b00} == `OCG_OFF_FLAGS)) ?
    (wr_val & `OCG_IRQ_MASK) : 16'h0000;

// A new event in the clearing cycle wins over the clear
always @*
begin
    flags_d = ((flags_q & ~flag_clr) | evt_set) & `OCG_IRQ_MASK;
end

always @(posedge CLOCK)
begin
    if (!RESETN)
    begin
        ls_ctrl_q <= `OCG_LS_RESET;
        hs_ctrl_q <= `OCG_HS_RESET;
        flags_q <= 16'h0000;
        en_q <= 16'h0000;
        irq_q <= 1'b0;
        stable_q <= 3'h0;
    end
    else
    begin
        ls_ctrl_q <= ls_ctrl_d;
        hs_ctrl_q <= hs_ctrl_d;
        flags_q <= flags_d;
        en_q <= en_d;
        irq_q <= |(flags_d & en_d);
        if (hs_done)
            stable_q[2] <= 1'b1;
        else if (!HS_OSC_ON)
            stable_q[2] <= 1'b0;
        if (ls_done)
            stable_q[1] <= 1'b1;
        else if (!LS_OSC_ON)
            stable_q[1] <= 1'b0;
        if (in_done)
            stable_q[0] <= 1'b1;
        else if (!IN_OSC_ON)
            stable_q[0] <= 1'b0;
    end
end

assign IRQ = irq_q;
assign STABLE = stable_q;

// ----------------------------------------------------------------
// Stabilization wait counters
// ----------------------------------------------------------------
assign ls_target = ls_wait(ls_ctrl_q[`OCG_LS_WAIT_LSB+1:`OCG_LS_WAIT_LSB]);
assign hs_target = hs_wait(hs_ctrl_q[`OCG_HS_WAIT_LSB+2:`OCG_HS_WAIT_LSB]);

ocg_settle #(.WIDTH(CNT_W)) u_ls_settle (
    .clk(CLOCK),
    .resetn(RESETN),
    .osc_on(LS_OSC_ON),
    .osc_tick(LS_OSC_TICK),
    .target(ls_target),
    .busy_q(ls_busy),
    .done_q(ls_done)
);

ocg_settle #(.WIDTH(CNT_W)) u_hs_settle (
    .clk(CLOCK),
    .resetn(RESETN),
    .osc_on(HS_OSC_ON),
    .osc_tick(HS_OSC_TICK),
    .target(hs_target),
    .busy_q(hs_busy),
    .done_q(hs_done)
);

// The internal oscillator runs at reset release; its counter sees no edge
ocg_settle #(.WIDTH(CNT_W)) u_in_settle (
    .clk(CLOCK),
    .resetn(RESETN),
    .osc_on(IN_OSC_ON),
    .osc_tick(IN_OSC_TICK),
    .target(IN_WAIT),
    .busy_q(in_busy),
    .done_q(in_done)
);

// ----------------------------------------------------------------
// Oscillator settings out
// ----------------------------------------------------------------
ocg_gain_sel u_gain (
    .clk(CLOCK),
    .resetn(RESETN),
    .boost_active(ls_busy),
    .boost_gain(ls_ctrl_q[`OCG_LS_BOOST_LSB+1:`OCG_LS_BOOST_LSB]),
    .normal_gain(ls_ctrl_q[`OCG_LS_NORM_LSB+1:`OCG_LS_NORM_LSB]),
    .hs_type(hs_ctrl_q[`OCG_HS_TYPE_LSB+1:`OCG_HS_TYPE_LSB]),
    .hs_gain(hs_ctrl_q[`OCG_HS_INV_LSB+1:`OCG_HS_INV_LSB]),
    .ls_gain_q(LOW_SPEED_GAIN),
    .hs_gain_q(HIGH_SPEED_INVERTER_GAIN),
    .hs_gain_en_q(HIGH_SPEED_GAIN_EN)
);

assign LOW_SPEED_BOOSTING = ls_busy;
assign LOW_SPEED_GATE_CAP_CODE = ls_ctrl_q[`OCG_LS_CAP_LSB+2:`OCG_LS_CAP_LSB];
assign HIGH_SPEED_INTERNAL_FREQ = hs_ctrl_q[`OCG_HS_FREQ_LSB+2:`OCG_HS_FREQ_LSB];
assign HIGH_SPEED_OSC_TYPE = hs_ctrl_q[`OCG_HS_TYPE_LSB+1:`OCG_HS_TYPE_LSB];

// Unused protection, upper data and strobe inputs of the bus, and unused busy flags
wire unused_ok;
assign unused_ok = &{1'b0, S_AXI_AWPROT, S_AXI_ARPROT, S_AXI_WDATA[31:16],
    S_AXI_WSTRB[3:2], hs_busy, in_busy};

endmodule

// ===== rtl/ocg_defs.vh
// Register map, field layout, reset values and wait counts of the clock block
`ifndef OCG_DEFS_VH
`define OCG_DEFS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OCG_OFF_LS_CTRL 4'h0
`define OCG_OFF_HS_CTRL 4'h4
`define OCG_OFF_FLAGS 4'h8
`define OCG_OFF_ENABLES 4'hc

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OCG_LS_CAP_LSB 8
`define OCG_LS_BOOST_LSB 6
`define OCG_LS_NORM_LSB 4
`define OCG_LS_WAIT_LSB 0
`define OCG_HS_FREQ_LSB 10
`define OCG_HS_TYPE_LSB 8
`define OCG_HS_INV_LSB 4
`define OCG_HS_WAIT_LSB 0
`define OCG_BIT_LS_STOP 5
`define OCG_BIT_TRIM 4
`define OCG_BIT_HS_STA 2
`define OCG_BIT_LS_STA 1
`define OCG_BIT_IN_STA 0

// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define OCG_LS_MASK 16'h07f3
`define OCG_HS_MASK 16'h1f37
`define OCG_IRQ_MASK 16'h0037
`define OCG_LS_RESET 16'h0092
`define OCG_HS_RESET 16'h0c10

// ----------------------------------------------------------------
// Codes and wait counts in oscillator clocks
// ----------------------------------------------------------------
`define OCG_TYPE_XTAL 2'h2
`define OCG_WAIT_4 17'h00004
`define OCG_WAIT_16 17'h00010
`define OCG_WAIT_64 17'h00040
`define OCG_WAIT_256 17'h00100
`define OCG_WAIT_1024 17'h00400
`define OCG_WAIT_4096 17'h01000
`define OCG_WAIT_16384 17'h04000
`define OCG_WAIT_65536 17'h10000
`define OCG_IN_WAIT_DEF 17'h00400

// ----------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------
`define OCG_RESP_OKAY 2'h0
`define OCG_RESP_SLVERR 2'h2

`endif

// ===== rtl/ocg_settle.v
// Stabilization wait counter for one oscillator
`timescale 1ns/1ps
module ocg_settle #(
    parameter WIDTH = 17
) (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Oscillator side
    input wire osc_on,
    input wire osc_tick,
    input wire [WIDTH-1:0] target,
    // Status
    output reg busy_q,
    output reg done_q
);

reg on_prev_q;
reg [WIDTH-1:0] cnt_q;
reg [WIDTH-1:0] tgt_q;
wire [WIDTH-1:0] cnt_inc;

assign cnt_inc = cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};

// Previous level resets high so an oscillator already running at reset
// release gives no start edge and hence no completion event.
always @(posedge clk)
begin
    if (!resetn)
    begin
        on_prev_q <= 1'b1;
        cnt_q <= {WIDTH{1'b0}};
        tgt_q <= {WIDTH{1'b0}};
        busy_q <= 1'b0;
        done_q <= 1'b0;
    end
    else
    begin
        on_prev_q <= osc_on;
        done_q <= 1'b0;
        if (osc_on && !on_prev_q)
        begin
            cnt_q <= {WIDTH{1'b0}};
            tgt_q <= target;
            busy_q <= 1'b1;
        end
        else if (busy_q && !osc_on)
        begin
            busy_q <= 1'b0;
        end
        else if (busy_q && osc_tick)
        begin
            cnt_q <= cnt_inc;
            if (cnt_inc == tgt_q)
            begin
                busy_q <= 1'b0;
                done_q <= 1'b1;
            end
        end
    end
end

endmodule

// ===== rtl/ocg_gain_sel.v
// Inverter gain selection for both oscillators
`timescale 1ns/1ps
`include "ocg_defs.vh"
module ocg_gain_sel (
    // Clock and reset
    input wire clk,
    input wire resetn,
    // Settings
    input wire boost_active,
    input wire [1:0] boost_gain,
    input wire [1:0] normal_gain,
    input wire [1:0] hs_type,
    input wire [1:0] hs_gain,
    // Applied values
    output reg [1:0] ls_gain_q,
    output reg [1:0] hs_gain_q,
    output reg hs_gain_en_q
);

// Software keeps the boost code at or above the normal one; no clamp here
always @(posedge clk)
begin
    if (!resetn)
    begin
        ls_gain_q <= 2'h1;
        hs_gain_q <= 2'h0;
        hs_gain_en_q <= 1'b0;
    end
    else
    begin
        ls_gain_q <= boost_active ? boost_gain : normal_gain;
        hs_gain_en_q <= (hs_type == `OCG_TYPE_XTAL);
        hs_gain_q <= (hs_type == `OCG_TYPE_XTAL) ? hs_gain : 2'h0;
    end
end

endmodule

// ===== testbench/ocg_chk.sv
// Checker of bus handshakes, gain outputs, settle status and interrupt hold
`timescale 1ns/1ps
module ocg_chk (
    // Clock and reset
    input wire CLOCK,
    input wire RESETN,
    // Bus
    input wire S_AXI_AWVALID,
    input wire S_AXI_AWREADY,
    input wire S_AXI_WVALID,
    input wire S_AXI_WREADY,
    input wire S_AXI_BVALID,
    input wire S_AXI_ARVALID,
    input wire S_AXI_ARREADY,
    input wire S_AXI_RVALID,
    input wire S_AXI_RREADY,
    input wire [31:0] S_AXI_RDATA,
    // Oscillators
    input wire LS_OSC_ON,
    input wire HS_OSC_ON,
    input wire LOW_SPEED_BOOSTING,
    input wire [1:0] HIGH_SPEED_OSC_TYPE,
    input wire [1:0] HIGH_SPEED_INVERTER_GAIN,
    input wire HIGH_SPEED_GAIN_EN,
    input wire [2:0] STABLE,
    // Interrupt
    input wire IRQ
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    sequence rd_taken;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // Two idle cycles mean no register write can still be landing
    sequence wr_idle;
        !S_AXI_AWVALID && !S_AXI_WVALID;
    endsequence

    read_answer_a: assert property (rd_taken |=> S_AXI_RVALID)
        else $error("read address taken but no read data next cycle");
    read_single_a: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID)
        else $error("read data repeated after handshake");
    read_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address accepted while data pending");
    write_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write accepted while response pending");
    upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
        else $error("reserved read bits not zero");
    hs_gain_on_a: assert property ((HIGH_SPEED_OSC_TYPE == 2'h2) [*2] |-> HIGH_SPEED_GAIN_EN)
        else $error("high-speed gain not applied for crystal type");
    hs_gain_off_a: assert property ((HIGH_SPEED_OSC_TYPE != 2'h2) [*2] |->
        !HIGH_SPEED_GAIN_EN && HIGH_SPEED_INVERTER_GAIN == 2'h0)
        else $error("high-speed gain applied for non-crystal type");
    ls_stop_clr_a: assert property ((!LS_OSC_ON) [*3] |-> !STABLE[1] && !LOW_SPEED_BOOSTING)
        else $error("low-speed status kept while oscillator off");
    hs_stop_clr_a: assert property ((!HS_OSC_ON) [*3] |-> !STABLE[2])
        else $error("high-speed stable kept while oscillator off");
    irq_hold_a: assert property (wr_idle ##1 (wr_idle and IRQ) |=> IRQ)
        else $error("interrupt dropped without a register write");
endmodule

bind ocg_top ocg_chk chk_u (
    .CLOCK(CLOCK),
    .RESETN(RESETN),
    .S_AXI_AWVALID(S_AXI_AWVALID),
    .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WVALID(S_AXI_WVALID),
    .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BVALID(S_AXI_BVALID),
    .S_AXI_ARVALID(S_AXI_ARVALID),
    .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY),
    .S_AXI_RDATA(S_AXI_RDATA),
    .LS_OSC_ON(LS_OSC_ON),
    .HS_OSC_ON(HS_OSC_ON),
    .LOW_SPEED_BOOSTING(LOW_SPEED_BOOSTING),
    .HIGH_SPEED_OSC_TYPE(HIGH_SPEED_OSC_TYPE),
    .HIGH_SPEED_INVERTER_GAIN(HIGH_SPEED_INVERTER_GAIN),
    .HIGH_SPEED_GAIN_EN(HIGH_SPEED_GAIN_EN),
    .STABLE(STABLE),
    .IRQ(IRQ)
);

// ===== testbench/oscillator_config_and_clock_irq_test.sv
// Register, event and settle-wait tests of the clock block
`timescale 1ns/1ps
module oscillator_config_and_clock_irq_test;
    reg clk = 1'b0;
    reg rstn = 1'b0;
    reg awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    reg [7:0] awa = 8'h00, ara = 8'h00;
    reg [31:0] wd = 32'h00000000;
    reg [3:0] strb = 4'hf;
    reg [2:0] on = 3'h7, tick = 3'h0;
    reg [1:0] evt = 2'h0;
    wire awr, wr, bv, arr, rv, irq, hs_en, boost;
    wire [1:0] br, rr, ls_gain, hs_type, hs_gain;
    wire [2:0] cap, freq, stable;
    wire [31:0] rd;
    integer num_errors = 0;
    integer compares = 0;
    reg [15:0] i, v;
    reg [31:0] rdat;
    reg [1:0] resp;

    always #4 clk = ~clk;

    // Short settle counts keep the run brief; 4096 and below stay real, except the internal wait, cut to 8
    ocg_top #(.LS_WAIT_3(17'd40), .LS_WAIT_2(17'd20), .HS_WAIT_7(17'd40),
        .HS_WAIT_6(17'd20), .IN_WAIT(17'd8)) dut_u (
        .CLOCK(clk), .RESETN(rstn),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(awa[2:0]),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(strb),
        .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_BRESP(br),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(ara[2:0]),
        .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
        .LS_OSC_ON(on[1]), .LS_OSC_TICK(tick[1]), .HS_OSC_ON(on[2]), .HS_OSC_TICK(tick[2]),
        .IN_OSC_ON(on[0]), .IN_OSC_TICK(tick[0]),
        .LS_STOP_EVT(evt[0]), .TRIM_DONE_EVT(evt[1]),
        .LOW_SPEED_GATE_CAP_CODE(cap), .LOW_SPEED_GAIN(ls_gain), .LOW_SPEED_BOOSTING(boost),
        .HIGH_SPEED_INTERNAL_FREQ(freq), .HIGH_SPEED_OSC_TYPE(hs_type),
        .HIGH_SPEED_INVERTER_GAIN(hs_gain), .HIGH_SPEED_GAIN_EN(hs_en),
        .STABLE(stable), .IRQ(irq)
    );

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp)
            begin
                num_errors = num_errors + 1;
                $display("Error %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    task axi_wr(input [7:0] a, input [15:0] d);
        reg aw_ok;
        reg w_ok;
        begin
            @(posedge clk);
            awv <= 1'b1;
            awa <= a;
            wv <= 1'b1;
            wd <= {16'h0000, d};
            bry <= 1'b1;
            aw_ok = 1'b0;
            w_ok = 1'b0;
            while (!(aw_ok && w_ok))
            begin
                @(posedge clk);
                if (!aw_ok && awr)
                begin
                    aw_ok = 1'b1;
                    awv <= 1'b0;
                end
                if (!w_ok && wr)
                begin
                    w_ok = 1'b1;
                    wv <= 1'b0;
                end
            end
            while (!bv) @(posedge clk);
            resp = br;
            bry <= 1'b0;
        end
    endtask

    task axi_rd(input [7:0] a);
        begin
            @(posedge clk);
            arv <= 1'b1;
            ara <= a;
            rry <= 1'b1;
            @(posedge clk);
            while (!arr) @(posedge clk);
            arv <= 1'b0;
            @(posedge clk);
            while (!rv) @(posedge clk);
            rdat = rd;
            resp = rr;
            rry <= 1'b0;
        end
    endtask

    // Restart oscillator s, tick it n times; flag bit and status index equal s
    task run_wait(input integer s, input integer n);
        begin
            @(posedge clk) on[s] <= 1'b0;
            repeat (4) @(posedge clk);
            on[s] <= 1'b1;
            repeat (2) @(posedge clk);
            repeat (n - 1)
            begin
                @(posedge clk) tick[s] <= 1'b1;
                @(posedge clk) tick[s] <= 1'b0;
            end
            repeat (3) @(posedge clk);
            axi_rd(8'h08);
            check("flag early", rdat[s], 1'b0);
            if (s == 1)
                check("boost gain", {boost, ls_gain}, 3'b111);
            @(posedge clk) tick[s] <= 1'b1;
            @(posedge clk) tick[s] <= 1'b0;
            repeat (4) @(posedge clk);
            axi_rd(8'h08);
            check("flag done", rdat, 32'h1 << s);
            check("stable", stable[s], 1'b1);
            check("irq done", irq, 1'b1);
            if (s == 1)
                check("normal gain", {boost, ls_gain}, 3'b001);
            axi_wr(8'h08, 16'h0001 << s);
            axi_rd(8'h08);
            check("flag clear", rdat, 32'h0);
        end
    endtask

    function integer hs_n(input integer c);
        hs_n = (c == 6) ? 20 : (c == 7) ? 40 : (4 << (2 * c));
    endfunction

    function integer ls_n(input integer c);
        ls_n = (c == 1) ? 4096 : (c == 2) ? 20 : 40;
    endfunction

    task finish_test;
        begin
            if (num_errors == 0 && compares > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        axi_rd(8'h00);
        check("ls reset", rdat, 32'h0092);
        axi_rd(8'h04);
        check("hs reset", rdat, 32'h0c10);
        axi_rd(8'h08);
        check("flags reset", rdat, 32'h0);
        check("boost reset", boost, 1'b0);
        axi_rd(8'h0c);
        check("enables reset", rdat, 32'h0);
        check("type reset", hs_en, 1'b0);
        for (i = 0; i < 8; i = i + 1)
        begin
            v = (i << 8) | ((i & 3) << 6) | ((i & 3) << 4) | (i & 3) | 16'hf80c;
            axi_wr(8'h00, v);
            axi_rd(8'h00);
            check("ls read", rdat, {16'h0000, v & 16'h07f3});
            check("cap", cap, i);
            v = (i << 10) | ((i & 3) << 8) | 16'he0f8;
            axi_wr(8'h04, v);
            axi_rd(8'h04);
            check("hs read", rdat, {16'h0000, v & 16'h1f37});
            check("freq", freq, i);
            check("type", hs_type, i & 3);
            check("gain en", hs_en, (i & 3) == 2);
            check("hs gain", hs_gain, ((i & 3) == 2) ? 3 : 0);
        end
        axi_wr(8'h0c, 16'hffff);
        axi_rd(8'h0c);
        check("enables read", rdat, 32'h0037);
        axi_wr(8'h0c, 16'h0000);
        for (i = 0; i < 2; i = i + 1)
        begin
            @(posedge clk) evt[i] <= 1'b1;
            @(posedge clk) evt[i] <= 1'b0;
            repeat (2) @(posedge clk);
            check("irq masked", irq, 1'b0);
            axi_rd(8'h08);
            check("event flag", rdat, 32'h20 >> i);
            axi_wr(8'h0c, 16'h0020 >> i);
            repeat (2) @(posedge clk);
            check("irq on", irq, 1'b1);
            axi_wr(8'h08, 16'h0000);
            axi_rd(8'h08);
            check("write zero", rdat, 32'h20 >> i);
            axi_wr(8'h08, 16'h0020 >> i);
            axi_rd(8'h08);
            check("event clear", rdat, 32'h0);
            check("irq off", irq, 1'b0);
            axi_wr(8'h0c, 16'h0000);
        end
        axi_wr(8'h0c, 16'h0007);
        run_wait(0, 8);
        for (i = 0; i < 8; i = i + 1)
        begin
            axi_wr(8'h04, 16'h0c10 | i);
            run_wait(2, hs_n(i));
        end
        for (i = 0; i < 4; i = i + 1)
        begin
            axi_wr(8'h00, 16'h00d0 | i);
            run_wait(1, ls_n(i));
        end
        strb <= 4'h2;
        axi_wr(8'h00, 16'h0500);
        axi_rd(8'h00);
        check("byte strobe", rdat, 32'h05d3);
        axi_wr(8'h10, 16'hffff);
        check("unmapped bresp", resp, 2'h2);
        axi_rd(8'h10);
        check("unmapped rresp", resp, 2'h2);
        check("unmapped data", rdat, 32'h0);
        finish_test;
    end

    // Full run needs about 20000 cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        num_errors = num_errors + 1;
        finish_test;
    end
endmodule
